// File: eept_event_source.sv
// Partner model: the switches or controller that drive the event inputs.
// Assumes the bench names the wanted levels; pins change off the clock edge.
`timescale 1ns/1ps
`default_nettype none

module eept_event_source
	import eept_pkg::*;
(
	input  wire logic [EEPT_NUM_EVENTS-1:0] target,      // Levels asked for by the bench
	input  wire logic                       slow,        // Late settling of the pins
	output logic      [EEPT_NUM_EVENTS-1:0] event_input  // Event pins towards the device
);
	// ==========================================================
	// Pin drive
	// ==========================================================
	// Levels only change on request, so every pulse is as wide as the bench holds it
	initial event_input = '0;

	// Asynchronous to aclk: a prompt and a slow settling time
	always @(target)
	begin
		event_input <= #(slow ? 3.7 : 1.2) target;
	end
endmodule // eept_event_source

`default_nettype wire

// File: eept_event_sync.sv
// Three-stage synchroniser and edge detector for the event inputs.
// Assumes the event pins are asynchronous to aclk; one edge yields one pulse.
`timescale 1ns/1ps
`default_nettype none

module eept_event_sync
	import eept_pkg::*;
(
	input  wire logic                                 aclk,     // System clock
	input  wire logic                                 aresetn,  // Synchronous reset, active low
	input  wire logic [eept_pkg::EEPT_NUM_EVENTS-1:0] event_in, // Raw event pins
	output logic      [eept_pkg::EEPT_NUM_EVENTS-1:0] level,    // Filtered level
	output logic      [eept_pkg::EEPT_NUM_EVENTS-1:0] rise,     // One-cycle off-to-on pulse
	output logic      [eept_pkg::EEPT_NUM_EVENTS-1:0] fall      // One-cycle on-to-off pulse
);

	import eept_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [EEPT_NUM_EVENTS-1:0] s1;    // First stage, read only by s2
		logic [EEPT_NUM_EVENTS-1:0] s2;    // Second stage
		logic [EEPT_NUM_EVENTS-1:0] s3;    // Third stage
		logic [EEPT_NUM_EVENTS-1:0] level; // Accepted level
		logic [EEPT_NUM_EVENTS-1:0] rise;  // Edge pulses
		logic [EEPT_NUM_EVENTS-1:0] fall;
	} eept_sync_t;

	eept_sync_t st_reg;  // Registered state
	eept_sync_t st_next; // Next state

	// Level changes only once stages two and three agree, filtering one-cycle glitches
	always_comb
	begin
		st_next       = st_reg;
		st_next.s1    = event_in;
		st_next.s2    = st_reg.s1;
		st_next.s3    = st_reg.s2;
		st_next.level = st_reg.level;
		for (int i = 0; i < EEPT_NUM_EVENTS; i++)
		begin
			if (st_reg.s2[i] == st_reg.s3[i])
			begin
				st_next.level[i] = st_reg.s2[i];
			end
		end
		st_next.rise = st_next.level & ~st_reg.level;
		st_next.fall = ~st_next.level & st_reg.level;
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign level = st_reg.level;
	assign rise  = st_reg.rise;
	assign fall  = st_reg.fall;

	// ==========================================================
	// Checks
	// ==========================================================
	chk_single_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		(rise != '0) |=> ((rise & $past(rise)) == '0))
		else $error("Edge pulse lasted more than one cycle");

endmodule // eept_event_sync

`default_nettype wire

// File: eept_path_trigger.sv
// Event edge path trigger: maps event input edges to path starts 51 to 63.
// Assumes an AXI4-Lite master and a path executor that takes one start per pulse.
`timescale 1ns/1ps
`default_nettype none

module eept_path_trigger
	import eept_pkg::*;
(
	input  wire logic                           aclk,            // System clock, 200 MHz
	input  wire logic                           aresetn,         // Synchronous reset, active low
	input  wire logic [eept_pkg::EEPT_NUM_EVENTS-1:0] event_input, // Event pins, bit 0 is input 1
	output logic                                path_start_valid,// One-cycle start pulse
	output logic      [5:0]                     path_start_num,  // Path to start
	input  wire logic [15:0]                    awaddr,
	input  wire logic                           awvalid,
	output logic                                awready,
	input  wire logic [31:0]                    wdata,
	input  wire logic [3:0]                     wstrb,
	input  wire logic                           wvalid,
	output logic                                wready,
	output logic      [1:0]                     bresp,
	output logic                                bvalid,
	input  wire logic                           bready,
	input  wire logic [15:0]                    araddr,
	input  wire logic                           arvalid,
	output logic                                arready,
	output logic      [31:0]                    rdata,
	output logic      [1:0]                     rresp,
	output logic                                rvalid,
	input  wire logic                           rready
);

	import eept_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [15:0] rise_sel;   // Rising-edge path selection
		logic [15:0] fall_sel;   // Falling-edge path selection
		logic        mode;       // Path-register control mode active
		logic [7:0]  pend;       // Pending starts: [3:0] rising, [7:4] falling
		logic        start_vld;  // Start pulse
		logic [5:0]  start_num;  // Start path number
		logic [5:0]  last_num;   // Last path started
		logic        aw_have;    // Write address held
		logic [15:0] aw_addr;
		logic        w_have;     // Write data held
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} eept_state_t;

	eept_state_t st_reg;  // Registered state
	eept_state_t st_next; // Next state

	logic [EEPT_NUM_EVENTS-1:0] ev_level; // Filtered levels
	logic [EEPT_NUM_EVENTS-1:0] ev_rise;  // Rising pulses
	logic [EEPT_NUM_EVENTS-1:0] ev_fall;  // Falling pulses

	// ==========================================================
	// Input synchroniser
	// ==========================================================
	eept_event_sync u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.event_in (event_input),
		.level    (ev_level),
		.rise     (ev_rise),
		.fall     (ev_fall)
	);

	// ==========================================================
	// Helpers
	// ==========================================================
	// True when every digit of a selection lies in 0..D
	function automatic logic sel_legal(input logic [15:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < EEPT_NUM_EVENTS; i++)
		begin
			if (v[4*i +: 4] > EEPT_DIGIT_MAX)
			begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	// Digit serving pending slot k (slots 4..7 use the falling setting)
	function automatic logic [3:0] slot_digit(input eept_state_t s, input int k);
		return (k < EEPT_NUM_EVENTS) ? s.rise_sel[4*(k%4) +: 4] : s.fall_sel[4*(k%4) +: 4];
	endfunction

	// Digits of the bus write after byte strobes are applied
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0])
		begin
			r[7:0] = d[7:0];
		end
		if (s[1])
		begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb
	begin
		logic [15:0] merged;  // Selection value after strobes
		logic        served;  // A pending slot was picked this cycle
		logic [3:0]  dig;     // Digit of the picked slot
		merged = '0;
		served = 1'b0;
		dig    = '0;
		st_next = st_reg;
		st_next.start_vld = 1'b0;

		// Serve the lowest pending slot; rising edges before falling, input 1 first
		for (int k = 0; k < 2*EEPT_NUM_EVENTS; k++)
		begin
			if (!served && st_reg.pend[k])
			begin
				served = 1'b1;
				dig = slot_digit(st_reg, k);
				st_next.pend[k] = 1'b0;
				if (st_reg.mode && dig != EEPT_DIGIT_NONE)
				begin
					st_next.start_vld = 1'b1;
					st_next.start_num = EEPT_PATH_BASE + {2'h0, dig};
					st_next.last_num  = EEPT_PATH_BASE + {2'h0, dig};
				end
			end
		end

		// New edges set pending after the serve clear, so a set wins over a clear
		for (int i = 0; i < EEPT_NUM_EVENTS; i++)
		begin
			if (st_reg.mode && ev_rise[i] && st_reg.rise_sel[4*i +: 4] != EEPT_DIGIT_NONE)
			begin
				st_next.pend[i] = 1'b1;
			end
			if (st_reg.mode && ev_fall[i] && st_reg.fall_sel[4*i +: 4] != EEPT_DIGIT_NONE)
			begin
				st_next.pend[EEPT_NUM_EVENTS + i] = 1'b1;
			end
		end

		// Leaving path-register mode drops any queued start
		if (!st_reg.mode)
		begin
			st_next.pend = '0;
		end

		// Write channel: address and data taken in either order
		if (awvalid && st_reg.awready)
		begin
			st_next.aw_have = 1'b1;
			st_next.aw_addr = awaddr;
		end
		if (wvalid && st_reg.wready)
		begin
			st_next.w_have = 1'b1;
			st_next.w_data = wdata;
			st_next.w_strb = wstrb;
		end
		if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid)
		begin
			st_next.aw_have = 1'b0;
			st_next.w_have  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = EEPT_RESP_OKAY;
			unique case (st_reg.aw_addr)
				EEPT_ADDR_RISE_SEL:
				begin
					merged = merge16(st_reg.rise_sel, st_reg.w_data, st_reg.w_strb);
					// Out-of-range digits are refused whole so a setting is never partial
					if (sel_legal(merged))
					begin
						st_next.rise_sel = merged;
					end
					else
					begin
						st_next.bresp = EEPT_RESP_SLVERR;
					end
				end
				EEPT_ADDR_FALL_SEL:
				begin
					merged = merge16(st_reg.fall_sel, st_reg.w_data, st_reg.w_strb);
					if (sel_legal(merged))
					begin
						st_next.fall_sel = merged;
					end
					else
					begin
						st_next.bresp = EEPT_RESP_SLVERR;
					end
				end
				EEPT_ADDR_MODE_CTRL:
				begin
					if (st_reg.w_strb[0])
					begin
						st_next.mode = st_reg.w_data[EEPT_MODE_BIT];
					end
				end
				EEPT_ADDR_STATUS: ; // Status is read-only; writes are ignored
				default:
				begin
					st_next.bresp = EEPT_RESP_SLVERR;
				end
			endcase
		end
		if (st_reg.bvalid && bready)
		begin
			st_next.bvalid = 1'b0;
		end
		st_next.awready = !st_next.aw_have && !st_next.bvalid;
		st_next.wready  = !st_next.w_have && !st_next.bvalid;

		// Read channel: one read at a time
		if (arvalid && st_reg.arready)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = EEPT_RESP_OKAY;
			st_next.rdata  = '0;
			unique case (araddr)
				EEPT_ADDR_RISE_SEL:  st_next.rdata[15:0] = st_reg.rise_sel;
				EEPT_ADDR_FALL_SEL:  st_next.rdata[15:0] = st_reg.fall_sel;
				EEPT_ADDR_MODE_CTRL: st_next.rdata[EEPT_MODE_BIT] = st_reg.mode;
				EEPT_ADDR_STATUS:
				begin
					st_next.rdata[EEPT_ST_LEVEL_LSB +: 4] = ev_level;
					st_next.rdata[EEPT_ST_PEND_LSB +: 8]  = st_reg.pend;
					st_next.rdata[EEPT_ST_LAST_LSB +: 6]  = st_reg.last_num;
				end
				default:
				begin
					st_next.rresp = EEPT_RESP_SLVERR;
				end
			endcase
		end
		else if (st_reg.rvalid && rready)
		begin
			st_next.rvalid = 1'b0;
		end
		st_next.arready = !st_next.rvalid;
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg          <= '0;
			st_reg.rise_sel <= EEPT_RST_RISE_SEL;
			st_reg.fall_sel <= EEPT_RST_FALL_SEL;
			st_reg.mode     <= EEPT_RST_MODE;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register
	// ==========================================================
	assign path_start_valid = st_reg.start_vld;
	assign path_start_num   = st_reg.start_num;
	assign awready          = st_reg.awready;
	assign wready           = st_reg.wready;
	assign bvalid           = st_reg.bvalid;
	assign bresp            = st_reg.bresp;
	assign arready          = st_reg.arready;
	assign rvalid           = st_reg.rvalid;
	assign rdata            = st_reg.rdata;
	assign rresp            = st_reg.rresp;

	// ==========================================================
	// Checks
	// ==========================================================
	chk_rise_queued: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.mode && ev_rise[0] && st_reg.rise_sel[3:0] != 4'h0) |=> st_reg.pend[0])
		else $error("Rising edge on input 1 did not queue a start");

	chk_fall_queued: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.mode && ev_fall[3] && st_reg.fall_sel[15:12] != 4'h0) |=> st_reg.pend[7])
		else $error("Falling edge on input 4 did not queue a start");

	chk_zero_digit: assert property (@(posedge aclk) disable iff (!aresetn)
		(!st_reg.pend[1] && st_reg.rise_sel[7:4] == 4'h0) |=> !st_reg.pend[1])
		else $error("Zero digit queued a start");

	chk_start_range: assert property (@(posedge aclk) disable iff (!aresetn)
		path_start_valid |-> (path_start_num >= 6'h33 && path_start_num <= 6'h3F))
		else $error("Started path outside 51 to 63");

	chk_start_number: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.mode && st_reg.pend[0] && st_reg.rise_sel[3:0] != 4'h0)
		|=> (path_start_valid && path_start_num == 6'h32 + {2'h0, $past(st_reg.rise_sel[3:0])}))
		else $error("Wrong path number for input 1 rising digit");

	chk_digit_limit: assert property (@(posedge aclk) disable iff (!aresetn)
		sel_legal(st_reg.rise_sel) && sel_legal(st_reg.fall_sel))
		else $error("Selection digit above D stored");

	chk_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!st_reg.mode |=> (!path_start_valid && st_reg.pend == 8'h00))
		else $error("Start produced outside path-register mode");

	chk_one_start: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.pend == 8'h01 && ev_rise == 4'h0 && ev_fall == 4'h0) |=> ##1 !path_start_valid)
		else $error("One edge produced more than one start");

endmodule // eept_path_trigger

`default_nettype wire

// File: eept_path_trigger_tb.sv
// Self-checking bench: AXI4-Lite master, queue model of path starts.
// Assumes eept_pkg and the event source partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module eept_path_trigger_tb;
	import eept_pkg::*;

	// ==========================================================
	// Signals
	// ==========================================================
	logic        aclk, aresetn, slow, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0]  target, ev, wstrb;
	logic        path_start_valid, awready, wready, bvalid, arready, rvalid;
	logic [5:0]  path_start_num;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rs;
	int          fails, check_count, cyc, last_m;
	int          exp_q[$];        // Expected path numbers in order
	logic [15:0] rise_m, fall_m;  // Model copies of the selections
	logic        mode_m;          // Model of the mode bit
	logic [3:0]  lvl_m;           // Model of the pin levels

	eept_event_source u_eept_event_source (.target(target), .slow(slow), .event_input(ev));

	eept_path_trigger u_eept_path_trigger (
		.aclk(aclk), .aresetn(aresetn), .event_input(ev),
		.path_start_valid(path_start_valid), .path_start_num(path_start_num),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ==========================================================
	// Clock, timeout and checking helpers
	// ==========================================================
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic end_sim();
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Ceiling well above the roughly 1700 cycles the sequence needs
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			$display("MISMATCH t=%0t timeout", $time);
			end_sim();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Every start pulse is matched against the head of the model queue
	always @(posedge aclk)
	begin
		if (path_start_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(1, 0, "unexpected path start");
			else
				check({26'h0, path_start_num}, exp_q.pop_front(), "path number");
		end
	end

	// ==========================================================
	// AXI4-Lite master tasks
	// ==========================================================
	task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er}, "write response");
	endtask

	task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge aclk);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	// ==========================================================
	// Model-driven stimulus
	// ==========================================================
	// Selection write: digits above D are refused and leave the register alone
	task automatic write_sel(input logic rise, input logic [15:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++)
			if (v[4*i+:4] > EEPT_DIGIT_MAX)
				ok = 1'b0;
		axi_write(rise ? EEPT_ADDR_RISE_SEL : EEPT_ADDR_FALL_SEL, {16'h0, v},
			ok ? EEPT_RESP_OKAY : EEPT_RESP_SLVERR);
		if (ok && rise)
			rise_m = v;
		else if (ok)
			fall_m = v;
		axi_read(rise ? EEPT_ADDR_RISE_SEL : EEPT_ADDR_FALL_SEL, rd, rs);
		check(rd, {16'h0, rise ? rise_m : fall_m}, "selection read back");
	endtask

	// Toggle pins; starts queue rises input 1..4 first, then falls
	task automatic toggle(input logic [3:0] m);
		logic [3:0] nl;
		nl = lvl_m ^ m;
		for (int i = 0; i < 4; i++)
			if (mode_m && m[i] && nl[i] && rise_m[4*i+:4] != EEPT_DIGIT_NONE)
				exp_q.push_back(50 + int'(rise_m[4*i+:4]));
		for (int i = 0; i < 4; i++)
			if (mode_m && m[i] && !nl[i] && fall_m[4*i+:4] != EEPT_DIGIT_NONE)
				exp_q.push_back(50 + int'(fall_m[4*i+:4]));
		// Starts are served in push order, so the tail is the last path
		if (exp_q.size() != 0)
			last_m = exp_q[$];
		lvl_m = nl;
		@(posedge aclk);
		target <= nl;
		repeat (24) @(posedge aclk);
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		{aresetn, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
		{target, lvl_m, rise_m, fall_m, mode_m} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{fails, check_count, cyc, last_m} = '0;
		void'($urandom(99052));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset values and an unmapped place
		axi_read(EEPT_ADDR_RISE_SEL, rd, rs);
		check(rd, {16'h0, EEPT_RST_RISE_SEL}, "rise select reset");
		axi_read(EEPT_ADDR_FALL_SEL, rd, rs);
		check(rd, {16'h0, EEPT_RST_FALL_SEL}, "fall select reset");
		axi_read(16'h0100, rd, rs);
		check({30'h0, rs}, {30'h0, EEPT_RESP_SLVERR}, "unmapped read");
		check(rd, 32'h0000_0000, "unmapped read data");
		write_sel(1'b1, 16'h0E00);
		// Outside path-register mode edges start nothing
		write_sel(1'b1, 16'h1111);
		write_sel(1'b0, 16'h2222);
		toggle(4'hF);
		toggle(4'hF);
		axi_write(EEPT_ADDR_MODE_CTRL, 32'h1, EEPT_RESP_OKAY);
		mode_m = 1'b1;
		// Every non-zero digit code on rising edges, falling edges set to none
		write_sel(1'b0, 16'h0000);
		for (int d = 1; d <= 13; d++)
		begin
			write_sel(1'b1, {4{4'(d)}});
			toggle(4'h1 << (d % 4));
			toggle(4'h1 << (d % 4));
		end
		// Random legal selections, single and simultaneous edges
		for (int k = 0; k < 12; k++)
		begin
			slow = k[0];
			write_sel(1'b1, {4'($urandom_range(13, 0)), 4'($urandom_range(13, 0)),
				4'($urandom_range(13, 0)), 4'($urandom_range(13, 0))});
			write_sel(1'b0, {4'($urandom_range(13, 0)), 4'($urandom_range(13, 0)),
				4'($urandom_range(13, 0)), 4'($urandom_range(13, 0))});
			toggle(4'($urandom_range(15, 1)));
			toggle(4'hF);
		end
		repeat (30) @(posedge aclk);
		check(exp_q.size(), 0, "missing path starts");
		// Status: settled levels, nothing pending, last path started
		axi_read(EEPT_ADDR_STATUS, rd, rs);
		check(rd, (32'(last_m) << EEPT_ST_LAST_LSB) | (32'(lvl_m) << EEPT_ST_LEVEL_LSB),
			"status word");
		// Byte strobes: only the low byte of the selection is replaced
		wstrb <= 4'h1;
		axi_write(EEPT_ADDR_RISE_SEL, 32'h0000_E312, EEPT_RESP_OKAY);
		wstrb <= 4'hF;
		rise_m[7:0] = 8'h12;
		axi_read(EEPT_ADDR_RISE_SEL, rd, rs);
		check(rd, {16'h0, rise_m}, "strobed selection");
		// Status writes are ignored, unmapped writes are refused
		axi_write(EEPT_ADDR_STATUS, 32'hFFFF_FFFF, EEPT_RESP_OKAY);
		axi_write(16'h0100, 32'h0000_0000, EEPT_RESP_SLVERR);
		// Leaving path-register mode silences every edge
		axi_write(EEPT_ADDR_MODE_CTRL, 32'h0000_0000, EEPT_RESP_OKAY);
		mode_m = 1'b0;
		axi_read(EEPT_ADDR_MODE_CTRL, rd, rs);
		check(rd, 32'h0000_0000, "mode read back");
		toggle(4'hF);
		toggle(4'hF);
		check(exp_q.size(), 0, "starts left after mode off");
		end_sim();
	end
endmodule // eept_path_trigger_tb

`default_nettype wire

// File: eept_pkg.sv
// Constants and types shared by the event edge path trigger block.
// Assumes a 32-bit AXI4-Lite register bus and a 200 MHz single clock domain.
package eept_pkg;

	// ==========================================================
	// Register map: word indices, the bus sees four times these
	// ==========================================================
	localparam logic [15:0] EEPT_IDX_RISE_SEL  = 16'h05C4; // Rising-edge path selection
	localparam logic [15:0] EEPT_IDX_FALL_SEL  = 16'h05C6; // Falling-edge path selection
	localparam logic [15:0] EEPT_IDX_MODE_CTRL = 16'h05C8; // Control mode register
	localparam logic [15:0] EEPT_IDX_STATUS    = 16'h05C9; // Block status

	// Byte addresses are four times the index
	localparam logic [15:0] EEPT_ADDR_RISE_SEL  = 16'(EEPT_IDX_RISE_SEL << 2);
	localparam logic [15:0] EEPT_ADDR_FALL_SEL  = 16'(EEPT_IDX_FALL_SEL << 2);
	localparam logic [15:0] EEPT_ADDR_MODE_CTRL = 16'(EEPT_IDX_MODE_CTRL << 2);
	localparam logic [15:0] EEPT_ADDR_STATUS    = 16'(EEPT_IDX_STATUS << 2);

	// ==========================================================
	// Reset values and field layout
	// ==========================================================
	localparam logic [15:0] EEPT_RST_RISE_SEL = 16'h0000; // No path for any rising edge
	localparam logic [15:0] EEPT_RST_FALL_SEL = 16'h0000; // No path for any falling edge
	localparam logic        EEPT_RST_MODE     = 1'b0;     // Starts outside path-register mode
	localparam int          EEPT_MODE_BIT     = 0;        // Mode bit in control register
	localparam int          EEPT_ST_LEVEL_LSB = 0;        // Status: filtered input levels [3:0]
	localparam int          EEPT_ST_PEND_LSB  = 4;        // Status: pending starts [11:4]
	localparam int          EEPT_ST_LAST_LSB  = 16;       // Status: last path started [21:16]

	// ==========================================================
	// Selection digit coding
	// ==========================================================
	localparam int          EEPT_NUM_EVENTS   = 4;        // Event inputs served
	localparam logic [3:0]  EEPT_DIGIT_NONE   = 4'h0;     // Digit that starts nothing
	localparam logic [3:0]  EEPT_DIGIT_MAX    = 4'hD;     // Highest legal digit
	localparam logic [5:0]  EEPT_PATH_BASE    = 6'h32;    // Path number is base plus digit (50)

	// ==========================================================
	// AXI responses
	// ==========================================================
	localparam logic [1:0]  EEPT_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  EEPT_RESP_SLVERR  = 2'h2;

endpackage
